// [gsr_map.svh]
// Purpose: offsets, field positions and reset values of the gas sensor register bank
// Assumes: byte addresses on the two-wire target port, MSB of a register at its offset
// Notes: 16-bit registers occupy offset (high byte) and offset+1 (low byte)
`ifndef GSR_MAP_SVH
`define GSR_MAP_SVH

`define GSR_I2C_ADDR 7'h41
`define GSR_MAX_BYTES 4

// ==========================================
// register offsets
`define GSR_OFF_CONC 8'h02
`define GSR_OFF_FILT 8'h04
`define GSR_OFF_CMD 8'h05
`define GSR_OFF_INIT 8'h06
`define GSR_OFF_RECUR 8'h08
`define GSR_OFF_AZTGT 8'h0c
`define GSR_OFF_FRESH 8'h12
`define GSR_OFF_KNOWN 8'h14
`define GSR_OFF_ALT 8'h1e
`define GSR_OFF_SERIAL 8'h26
`define GSR_OFF_AZCTL 8'h4e

// ==========================================
// reset values
`define GSR_RST_CONC 16'h0000
`define GSR_RST_FILT 8'h10
`define GSR_RST_INIT 16'h2f40
`define GSR_RST_RECUR 16'h3600
`define GSR_RST_AZTGT 16'h0190
`define GSR_RST_FRESH 16'h0190
`define GSR_RST_KNOWN 16'h0000
`define GSR_RST_ALT 16'h2000
`define GSR_RST_AZCTL 8'h02

// ==========================================
// fields
`define GSR_CMD_AIR_BIT 0
`define GSR_CMD_KNOWN_BIT 2
`define GSR_AZ_ENABLED 8'h02

`endif

// [gsr_pkg.sv]
// Purpose: shared types of the gas sensor register bank
// Assumes: constants live in gsr_map.svh
// Notes: none
package gsr_pkg;

    typedef enum logic [1:0] {
        GSR_ZK_FRESH = 2'h0,
        GSR_ZK_KNOWN = 2'h1,
        GSR_ZK_AUTO = 2'h3
    } gsr_zero_t;

    // gray along idle, address, ack, write
    typedef enum logic [2:0] {
        GSR_ST_IDLE = 3'h0,
        GSR_ST_ADDR = 3'h1,
        GSR_ST_ACK = 3'h3,
        GSR_ST_WR = 3'h2,
        GSR_ST_RD = 3'h6,
        GSR_ST_RACK = 3'h7
    } gsr_i2c_state_t;

endpackage

// [gsr_i2c_target.sv]
// Purpose: two-wire target front end, bytes in and out
// Assumes: scl and sda_in already synchronous to clock
// Notes: sda is open drain, sda_oe high pulls the line low
`timescale 1ns/100ps
`include "gsr_map.svh"
module gsr_i2c_target #(
    parameter logic [6:0] TARGET_ADDR = `GSR_I2C_ADDR
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // bus pins
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // byte side
    output logic xfer_begin,
    output logic xfer_rw,
    output logic xfer_end,
    output logic byte_valid,
    output logic [7:0] byte_data,
    output logic rd_next,
    input wire logic [7:0] rd_byte
);
    gsr_pkg::gsr_i2c_state_t state_q;
    logic scl_p_q, sda_p_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] sh_q, tx_q;

    // refused at elaboration: addresses above 0x77 are reserved on the bus
    if (TARGET_ADDR > 7'h77) begin : g_bad_addr
        $error("target address out of the usable range");
    end

    // ==========================================
    // bus conditions
    wire scl_rise = scl & ~scl_p_q;
    wire scl_fall = ~scl & scl_p_q;
    wire start_c = scl & scl_p_q & sda_p_q & ~sda_in;
    wire stop_c = scl & scl_p_q & ~sda_p_q & sda_in;
    wire byte_done = scl_fall && (bit_cnt_q == 4'h8);
    wire addr_hit = sh_q[7:1] == TARGET_ADDR;
    wire in_ack = state_q == gsr_pkg::GSR_ST_ACK;
    wire in_rack = state_q == gsr_pkg::GSR_ST_RACK;
    wire load_c = scl_fall && ((in_ack && xfer_rw) || in_rack);

    assign sda_out = 1'b0;
    assign byte_data = sh_q;

    // ==========================================
    // sequencer
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= gsr_pkg::GSR_ST_IDLE;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            bit_cnt_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            xfer_rw <= 1'b0;
            sda_oe <= 1'b0;
            xfer_begin <= 1'b0;
            xfer_end <= 1'b0;
            byte_valid <= 1'b0;
            rd_next <= 1'b0;
        end else begin
            scl_p_q <= scl;
            sda_p_q <= sda_in;
            xfer_begin <= 1'b0;
            byte_valid <= 1'b0;
            rd_next <= load_c && !start_c && !stop_c;
            // a start or stop out of sequence ends the transfer at once
            xfer_end <= (start_c || stop_c) && (state_q != gsr_pkg::GSR_ST_IDLE);
            if (start_c) begin
                state_q <= gsr_pkg::GSR_ST_ADDR;
                bit_cnt_q <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_c) begin
                state_q <= gsr_pkg::GSR_ST_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (state_q)
                    gsr_pkg::GSR_ST_ADDR, gsr_pkg::GSR_ST_WR: begin
                        if (scl_rise) begin
                            sh_q <= {sh_q[6:0], sda_in};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (byte_done) begin
                            bit_cnt_q <= 4'h0;
                            if (state_q == gsr_pkg::GSR_ST_WR) begin
                                byte_valid <= 1'b1;
                                sda_oe <= 1'b1;
                                state_q <= gsr_pkg::GSR_ST_ACK;
                            end else if (addr_hit) begin
                                xfer_rw <= sh_q[0];
                                xfer_begin <= 1'b1;
                                sda_oe <= 1'b1;
                                state_q <= gsr_pkg::GSR_ST_ACK;
                            end else begin
                                state_q <= gsr_pkg::GSR_ST_IDLE;
                            end
                        end
                    end
                    gsr_pkg::GSR_ST_ACK, gsr_pkg::GSR_ST_RACK: begin
                        if (in_rack && scl_rise && sda_in) begin
                            state_q <= gsr_pkg::GSR_ST_IDLE;
                        end else if (load_c) begin
                            tx_q <= rd_byte;
                            sda_oe <= ~rd_byte[7];
                            bit_cnt_q <= 4'h0;
                            state_q <= gsr_pkg::GSR_ST_RD;
                        end else if (scl_fall) begin
                            sda_oe <= 1'b0;
                            state_q <= gsr_pkg::GSR_ST_WR;
                        end
                    end
                    gsr_pkg::GSR_ST_RD: begin
                        if (scl_rise) begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (byte_done) begin
                            sda_oe <= 1'b0;
                            state_q <= gsr_pkg::GSR_ST_RACK;
                        end else if (scl_fall) begin
                            sda_oe <= ~tx_q[6];
                            tx_q <= {tx_q[6:0], 1'b0};
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ==========================================
    // checks
    chk_addr_miss: assert property (@(posedge clock) disable iff (!rst_n)
        (state_q == gsr_pkg::GSR_ST_ADDR && byte_done && !addr_hit && !start_c && !stop_c)
        |=> (state_q == gsr_pkg::GSR_ST_IDLE && !sda_oe))
        else $error("foreign address was not ignored");

endmodule

// [gsr_regbank.sv]
// Purpose: gas sensor register bank behind a two-wire target port
// Assumes: meas_valid pulses once per half-second measurement
// Notes: zero requests go to the sensing core as one-cycle pulses
`timescale 1ns/100ps
`include "gsr_map.svh"
module gsr_regbank #(
    parameter int MAX_BYTES = `GSR_MAX_BYTES,
    parameter logic [6:0] TARGET_ADDR = `GSR_I2C_ADDR
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // two-wire bus pins
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // sensing core
    input wire logic meas_valid,
    input wire logic [15:0] meas_ppm,
    input wire logic [31:0] serial_number,
    // settings and zero requests
    output logic [7:0] filter_depth,
    output logic [15:0] altitude_value,
    output logic zero_req,
    output gsr_pkg::gsr_zero_t zero_kind,
    output logic [15:0] zero_target
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // the byte index is three bits wide and saturates at 7
    if (MAX_BYTES < 1 || MAX_BYTES > 7) begin : g_bad_bytes
        $error("MAX_BYTES must lie in 1..7");
    end

    logic xfer_begin, xfer_rw, xfer_end, byte_valid, rd_next;
    logic [7:0] byte_data, rd_byte_q;
    logic expect_ptr_q, recur_touched_q, first_done_q;
    logic [7:0] ptr_q, azctl_q;
    logic [2:0] idx_q;
    logic [15:0] conc_q, init_q, recur_q, aztgt_q, fresh_q, known_q, period_cnt_q;

    gsr_i2c_target #(
        .TARGET_ADDR(TARGET_ADDR)
    ) u_target (
        .clock(clock),
        .rst_n(rst_n),
        .scl(scl),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .xfer_begin(xfer_begin),
        .xfer_rw(xfer_rw),
        .xfer_end(xfer_end),
        .byte_valid(byte_valid),
        .byte_data(byte_data),
        .rd_next(rd_next),
        .rd_byte(rd_byte_q)
    );

    // ==========================================
    // byte addressing
    wire [7:0] wa = ptr_q + {5'h00, idx_q};
    // bytes past the limit are acknowledged but dropped
    wire wr_ev = byte_valid && !expect_ptr_q && (32'(idx_q) < MAX_BYTES);
    wire cmd_wr = wr_ev && (wa == `GSR_OFF_CMD);
    wire cmd_air = cmd_wr && byte_data[`GSR_CMD_AIR_BIT];
    wire cmd_known = cmd_wr && byte_data[`GSR_CMD_KNOWN_BIT];
    wire recur_wr = wr_ev && (wa == `GSR_OFF_RECUR || wa == `GSR_OFF_RECUR + 8'h01);
    wire az_en = azctl_q == `GSR_AZ_ENABLED;
    wire [15:0] cnt_nx = period_cnt_q + 16'h0001;
    wire init_due = !first_done_q && (cnt_nx >= init_q);
    wire recur_due = first_done_q && (recur_q != 16'h0000) && (cnt_nx >= recur_q);
    wire auto_fire = meas_valid && az_en && (init_due || recur_due);
    wire force_fire = xfer_end && recur_touched_q && (recur_q == 16'h0000) && az_en;

    // reads outside the map, and the write-only command, return zero
    function automatic logic [7:0] rd_mux(input logic [7:0] a);
        logic [7:0] r;
        r = 8'h00;
        if (a == `GSR_OFF_CONC) r = conc_q[15:8];
        else if (a == `GSR_OFF_CONC + 8'h01) r = conc_q[7:0];
        else if (a == `GSR_OFF_FILT) r = filter_depth;
        else if (a == `GSR_OFF_INIT) r = init_q[15:8];
        else if (a == `GSR_OFF_INIT + 8'h01) r = init_q[7:0];
        else if (a == `GSR_OFF_RECUR) r = recur_q[15:8];
        else if (a == `GSR_OFF_RECUR + 8'h01) r = recur_q[7:0];
        else if (a == `GSR_OFF_AZTGT) r = aztgt_q[15:8];
        else if (a == `GSR_OFF_AZTGT + 8'h01) r = aztgt_q[7:0];
        else if (a == `GSR_OFF_FRESH) r = fresh_q[15:8];
        else if (a == `GSR_OFF_FRESH + 8'h01) r = fresh_q[7:0];
        else if (a == `GSR_OFF_KNOWN) r = known_q[15:8];
        else if (a == `GSR_OFF_KNOWN + 8'h01) r = known_q[7:0];
        else if (a == `GSR_OFF_ALT) r = altitude_value[15:8];
        else if (a == `GSR_OFF_ALT + 8'h01) r = altitude_value[7:0];
        else if (a == `GSR_OFF_SERIAL) r = serial_number[31:24];
        else if (a == `GSR_OFF_SERIAL + 8'h01) r = serial_number[23:16];
        else if (a == `GSR_OFF_SERIAL + 8'h02) r = serial_number[15:8];
        else if (a == `GSR_OFF_SERIAL + 8'h03) r = serial_number[7:0];
        else if (a == `GSR_OFF_AZCTL) r = azctl_q;
        return r;
    endfunction

    wire [7:0] rd_sel = (32'(idx_q) < MAX_BYTES) ? rd_mux(wa) : 8'h00;

    // ==========================================
    // transfer bookkeeping
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            expect_ptr_q <= 1'b0;
            ptr_q <= 8'h00;
            idx_q <= 3'h0;
            rd_byte_q <= 8'h00;
            recur_touched_q <= 1'b0;
        end else begin
            rd_byte_q <= rd_sel;
            if (xfer_begin) begin
                expect_ptr_q <= !xfer_rw;
                idx_q <= 3'h0;
            end else if (byte_valid && expect_ptr_q) begin
                ptr_q <= byte_data;
                expect_ptr_q <= 1'b0;
            end else if ((byte_valid || rd_next) && idx_q != 3'h7) begin
                idx_q <= idx_q + 3'h1;
            end
            if (xfer_end) begin
                recur_touched_q <= 1'b0;
            end else if (recur_wr) begin
                recur_touched_q <= 1'b1;
            end
        end
    end

    // ==========================================
    // writable registers, high byte at the offset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            filter_depth <= `GSR_RST_FILT;
            init_q <= `GSR_RST_INIT;
            recur_q <= `GSR_RST_RECUR;
            aztgt_q <= `GSR_RST_AZTGT;
            fresh_q <= `GSR_RST_FRESH;
            known_q <= `GSR_RST_KNOWN;
            altitude_value <= `GSR_RST_ALT;
            azctl_q <= `GSR_RST_AZCTL;
        end else if (wr_ev) begin
            if (wa == `GSR_OFF_FILT) filter_depth <= byte_data;
            if (wa == `GSR_OFF_AZCTL) azctl_q <= byte_data;
            if (wa == `GSR_OFF_INIT) init_q[15:8] <= byte_data;
            if (wa == `GSR_OFF_INIT + 8'h01) init_q[7:0] <= byte_data;
            if (wa == `GSR_OFF_RECUR) recur_q[15:8] <= byte_data;
            if (wa == `GSR_OFF_RECUR + 8'h01) recur_q[7:0] <= byte_data;
            if (wa == `GSR_OFF_AZTGT) aztgt_q[15:8] <= byte_data;
            if (wa == `GSR_OFF_AZTGT + 8'h01) aztgt_q[7:0] <= byte_data;
            if (wa == `GSR_OFF_FRESH) fresh_q[15:8] <= byte_data;
            if (wa == `GSR_OFF_FRESH + 8'h01) fresh_q[7:0] <= byte_data;
            if (wa == `GSR_OFF_KNOWN) known_q[15:8] <= byte_data;
            if (wa == `GSR_OFF_KNOWN + 8'h01) known_q[7:0] <= byte_data;
            if (wa == `GSR_OFF_ALT) altitude_value[15:8] <= byte_data;
            if (wa == `GSR_OFF_ALT + 8'h01) altitude_value[7:0] <= byte_data;
        end
    end

    // ==========================================
    // measurement and auto-zero scheduling
    // the readout is held while a transfer runs so both bytes match
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            conc_q <= `GSR_RST_CONC;
            period_cnt_q <= 16'h0000;
            first_done_q <= 1'b0;
        end else begin
            if (meas_valid && (u_target.state_q == gsr_pkg::GSR_ST_IDLE)) begin
                conc_q <= meas_ppm;
            end
            if (auto_fire || force_fire) begin
                period_cnt_q <= 16'h0000;
                first_done_q <= 1'b1;
            end else if (meas_valid && az_en) begin
                period_cnt_q <= cnt_nx;
            end
        end
    end

    // ==========================================
    // zero requests; a host command beats an automatic one in the same cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            zero_req <= 1'b0;
            zero_kind <= gsr_pkg::GSR_ZK_FRESH;
            zero_target <= 16'h0000;
        end else begin
            zero_req <= cmd_air || cmd_known || auto_fire || force_fire;
            if (cmd_known) begin
                zero_kind <= gsr_pkg::GSR_ZK_KNOWN;
                zero_target <= known_q;
            end else if (cmd_air) begin
                zero_kind <= gsr_pkg::GSR_ZK_FRESH;
                zero_target <= fresh_q;
            end else if (auto_fire || force_fire) begin
                zero_kind <= gsr_pkg::GSR_ZK_AUTO;
                zero_target <= aztgt_q;
            end
        end
    end

    // ==========================================
    // checks
    chk_reset_values: assert property (!$past(rst_n) |-> init_q == 16'h2f40
        && recur_q == 16'h3600 && aztgt_q == 16'h0190 && fresh_q == 16'h0190
        && azctl_q == 8'h02)
        else $error("register reset value wrong");
    chk_conc_readout: assert property ((meas_valid && u_target.state_q == gsr_pkg::GSR_ST_IDLE)
        |=> (conc_q == $past(meas_ppm)) ##1 (!$stable(wa) || !$stable(conc_q)
        || wa != `GSR_OFF_CONC || idx_q != 3'h0 || rd_byte_q == conc_q[15:8]))
        else $error("concentration readout wrong");
    chk_air_zero: assert property ((cmd_air && !cmd_known)
        |=> zero_req && zero_kind == gsr_pkg::GSR_ZK_FRESH && zero_target == $past(fresh_q))
        else $error("fresh-air zero not issued");
    chk_known_zero: assert property (cmd_known
        |=> zero_req && zero_kind == gsr_pkg::GSR_ZK_KNOWN && zero_target == $past(known_q))
        else $error("known-gas zero not issued");
    chk_no_zero_cmd: assert property ((cmd_wr && !cmd_air && !cmd_known && !meas_valid)
        |=> !zero_req)
        else $error("zero issued for an empty command");
    chk_az_disabled: assert property ((!az_en && !cmd_wr) |=> !zero_req)
        else $error("auto-zero fired while disabled");
    chk_force_zero: assert property (force_fire
        |=> zero_req && zero_kind == gsr_pkg::GSR_ZK_AUTO && period_cnt_q == 16'h0000)
        else $error("forced auto-zero missing");
    chk_first_zero: assert property ((meas_valid && az_en && init_due && !cmd_wr)
        |=> zero_req && first_done_q && zero_target == $past(aztgt_q))
        else $error("initial auto-zero missing");
    chk_serial_read: assert property ((wa == `GSR_OFF_SERIAL && idx_q == 3'h0)
        |=> rd_byte_q == $past(serial_number[31:24]))
        else $error("serial number byte wrong");
    chk_byte_limit: assert property ((byte_valid && !expect_ptr_q && 32'(idx_q) >= MAX_BYTES)
        |=> $stable(init_q) && $stable(recur_q) && $stable(known_q))
        else $error("byte beyond limit was written");

endmodule

// [gsr_i2c_master.sv]
// Purpose: two-wire bus controller model for the register bank
// Assumes: sda has a pull-up, scl is driven by this model alone
// Notes: lw sets each half of the low phase, raise it to stall the bus
`timescale 1ns/100ps
module gsr_i2c_master (
    // clock
    input wire logic clock,
    // bus
    input wire logic sda_wire,
    output logic scl,
    output logic sda_drv,
    // read results
    output logic rd_done,
    output logic [7:0] rd_data
);
    int lw = 3;
    logic [6:0] dev_addr = 7'h41;
    logic last_ack;

    initial begin
        scl = 1'h1;
        sda_drv = 1'h1;
        rd_done = 1'h0;
        rd_data = 8'h00;
    end

    // ==========
    // bus cycles
    task automatic w(input int n);
        repeat (n) @(negedge clock);
    endtask

    // data moves only while scl is low, so no false start or stop
    task automatic bit_io(input logic b, output logic r);
        w(lw);
        sda_drv = b;
        w(lw);
        scl = 1'h1;
        w(4);
        r = sda_wire;
        scl = 1'h0;
    endtask

    task automatic xbyte(input logic [7:0] d, input logic ma, output logic [7:0] r,
        output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(ma, a);
    endtask

    task automatic start;
        w(lw);
        sda_drv = 1'h1;
        w(lw);
        scl = 1'h1;
        w(4);
        sda_drv = 1'h0;
        w(4);
        scl = 1'h0;
    endtask

    task automatic stop;
        w(lw);
        sda_drv = 1'h0;
        w(lw);
        scl = 1'h1;
        w(4);
        sda_drv = 1'h1;
        w(4);
    endtask

    task automatic wr(input logic [7:0] ptr, input int n, input logic [39:0] d);
        logic [7:0] r;
        logic a;
        start();
        xbyte({dev_addr, 1'h0}, 1'h1, r, last_ack);
        xbyte(ptr, 1'h1, r, a);
        for (int i = n - 1; i >= 0; i--) begin
            xbyte(d[8*i +: 8], 1'h1, r, a);
        end
        stop();
    endtask

    // pointer write, repeated start, then n bytes with nack on the last
    task automatic rd(input logic [7:0] ptr, input int n);
        logic [7:0] r;
        logic a;
        start();
        xbyte({dev_addr, 1'h0}, 1'h1, r, a);
        xbyte(ptr, 1'h1, r, a);
        start();
        xbyte({dev_addr, 1'h1}, 1'h1, r, last_ack);
        for (int i = n - 1; i >= 0; i--) begin
            xbyte(8'hff, i == 0, r, a);
            rd_data = r;
            rd_done = 1'h1;
            w(1);
            rd_done = 1'h0;
        end
        stop();
    endtask
endmodule

// [tb_top.sv]
// Purpose: self-checking bench for the gas sensor register bank
// Assumes: bus controller model in gsr_i2c_master.sv
// Notes: measurements are pulsed fast and intervals written small
`timescale 1ns/100ps
module tb_top;
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic meas_valid = 1'h0;
    logic [15:0] meas_ppm = 16'h0000;
    logic [31:0] serial_number = 32'h0000_0000;
    logic scl, sda_drv, sda_oe, rd_done, zero_req, sda_out;
    logic [7:0] rd_data, filter_depth;
    logic [15:0] altitude_value, zero_target, f, k, t;
    gsr_pkg::gsr_zero_t zero_kind;
    wire sda_wire = sda_drv & ~sda_oe;
    logic [7:0] exp_rd[$];
    logic [17:0] exp_zr[$];
    int n_fail = 0;
    int compares = 0;
    int seed = 22;

    always #4 clock = ~clock;

    gsr_regbank dut (.clock(clock), .rst_n(rst_n), .scl(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .meas_valid(meas_valid), .meas_ppm(meas_ppm),
        .serial_number(serial_number), .filter_depth(filter_depth),
        .altitude_value(altitude_value), .zero_req(zero_req), .zero_kind(zero_kind),
        .zero_target(zero_target));
    gsr_i2c_master mstr (.clock(clock), .sda_wire(sda_wire), .scl(scl),
        .sda_drv(sda_drv), .rd_done(rd_done), .rd_data(rd_data));

    // ==========
    // checking
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test;
        if (n_fail == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge clock) begin
        if (rd_done === 1'h1) begin
            if (exp_rd.size() == 0)
                chk("extra read", 1, 0);
            else
                chk("read byte", rd_data, exp_rd.pop_front());
        end
        if (zero_req === 1'h1) begin
            if (exp_zr.size() == 0)
                chk("extra zero", 1, 0);
            else
                chk("zero request", {zero_kind, zero_target}, exp_zr.pop_front());
        end
    end

    task automatic rdx(input logic [7:0] ptr, input int n, input logic [39:0] v);
        for (int i = n - 1; i >= 0; i--) begin
            exp_rd.push_back(v[8*i +: 8]);
        end
        mstr.rd(ptr, n);
    endtask

    // the gap lets an early zero pulse reach the monitor before any size check
    task automatic meas(input int n);
        repeat (n) begin
            @(negedge clock);
            meas_ppm = $random(seed);
            meas_valid = 1'h1;
            @(negedge clock);
            meas_valid = 1'h0;
            repeat (3) @(negedge clock);
        end
    endtask

    initial begin
        serial_number = $random(seed);
        repeat (12) @(negedge clock);
        rst_n = 1'h1;
        repeat (2) @(negedge clock);
        rdx(8'h06, 4, 32'h2f40_3600);
        rdx(8'h0c, 2, 32'h0190);
        rdx(8'h12, 2, 32'h0190);
        rdx(8'h04, 1, 32'h10);
        rdx(8'h1e, 2, 32'h2000);
        rdx(8'h4e, 1, 32'h02);
        rdx(8'h05, 1, 32'h00);
        rdx(8'h30, 1, 32'h00);
        mstr.wr(8'h26, 4, ~serial_number);
        rdx(8'h26, 4, serial_number);
        mstr.dev_addr = 7'h42;
        mstr.wr(8'h04, 1, 32'h55);
        chk("address nack", mstr.last_ack, 1);
        mstr.dev_addr = 7'h41;
        rdx(8'h04, 1, 32'h10);
        chk("address ack", mstr.last_ack, 0);
        f = $random(seed);
        mstr.wr(8'h04, 1, f);
        chk("filter", filter_depth, f[7:0]);
        mstr.wr(8'h1e, 2, f);
        chk("altitude", altitude_value, f);
        mstr.wr(8'h4e, 1, 32'h00);
        meas(1);
        rdx(8'h02, 2, meas_ppm);
        mstr.wr(8'h02, 2, ~meas_ppm);
        rdx(8'h02, 2, meas_ppm);
        // pointer-only write parks the read index on the readout during a measurement
        mstr.wr(8'h02, 0, 32'h0);
        meas(1);
        rdx(8'h02, 2, meas_ppm);
        mstr.lw = 9;
        f = $random(seed);
        k = $random(seed);
        mstr.wr(8'h12, 2, f);
        mstr.wr(8'h14, 2, k);
        exp_zr.push_back({2'h0, f});
        mstr.wr(8'h05, 1, 32'h01);
        exp_zr.push_back({2'h1, k});
        mstr.wr(8'h05, 1, 32'h04);
        exp_zr.push_back({2'h1, k});
        mstr.wr(8'h05, 1, 32'h05);
        mstr.wr(8'h05, 1, 32'h00);
        mstr.lw = 3;
        t = $random(seed);
        mstr.wr(8'h0c, 2, t);
        mstr.wr(8'h06, 4, 32'h0002_0003);
        meas(4);
        mstr.wr(8'h4e, 1, 32'h02);
        exp_zr.push_back({2'h3, t});
        meas(1);
        chk("initial early", exp_zr.size(), 1);
        meas(1);
        exp_zr.push_back({2'h3, t});
        meas(2);
        chk("recurring early", exp_zr.size(), 1);
        meas(1);
        exp_zr.push_back({2'h3, t});
        mstr.wr(8'h08, 2, 32'h0000);
        chk("forced zero", exp_zr.size(), 0);
        meas(4);
        mstr.wr(8'h4e, 1, 32'h00);
        mstr.wr(8'h08, 2, 32'h0000);
        // fifth byte would land on the recurring interval; it must be dropped
        mstr.wr(8'h04, 5, 40'h10_0012_3456);
        rdx(8'h06, 4, 32'h1234_0000);
        rdx(8'h22, 5, 40'h00_0000_0000);
        repeat (10) @(negedge clock);
        chk("sda drive level", sda_out, 0);
        chk("zero left", exp_zr.size(), 0);
        chk("read left", exp_rd.size(), 0);
        end_of_test();
    end

    initial begin
        repeat (80000) @(negedge clock);
        n_fail++;
        end_of_test();
    end
endmodule
